// ==== hdl/quadrature_decoder.sv ====
// Operation
// - one cycle is one bar-window pair
// - four states per cycle, alternating edges
// - leading channel gives count direction
// - count rate at most 60 kHz, resolved
// - one cycle equals one codestrip line
`timescale 1ns/100ps
`default_nettype none
module quadrature_decoder
    import qdec_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // encoder pins
    input wire logic chan_first,
    input wire logic chan_second,
    // position results and status flags
    output logic [pos_width-1:0] position,
    output logic [pos_width-1:0] line_count,
    output logic direction_up,
    output logic step,
    output logic double_change,
    output logic rate_exceeded
);
    logic [1:0] pins_sync;
    logic [1:0] prev;
    logic primed;
    logic [1:0] phase;
    logic [gap_width-1:0] gap;

    pin_sync #(.width(2)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pin({chan_second, chan_first}),
        .sync(pins_sync)
    );

    // gray state: first leads second when counting up
    wire logic [1:0] cur = pins_sync;
    wire logic changed = primed && (cur != prev);
    wire logic both_changed = primed && (cur == ~prev);
    wire logic fwd = changed && !both_changed &&
        ((prev == 2'h0 && cur == 2'h1) || (prev == 2'h1 && cur == 2'h3) ||
         (prev == 2'h3 && cur == 2'h2) || (prev == 2'h2 && cur == 2'h0));
    wire logic rev = changed && !both_changed && !fwd;
    wire logic too_fast = (fwd || rev) &&
        (gap < gap_width'(count_period_cycles / states_per_cycle));
    // four steps make one line
    wire logic line_up = fwd && phase == 2'h3;
    wire logic line_dn = rev && phase == 2'h0;
    wire logic [pos_width-1:0] next_position =
        fwd ? position + 1'b1 : (rev ? position - 1'b1 : position);
    wire logic [pos_width-1:0] next_line_count =
        line_up ? line_count + 1'b1 :
        (line_dn ? line_count - 1'b1 : line_count);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            prev <= 2'h0;
            primed <= 1'b0;
        end
        else
        begin
            prev <= cur;
            primed <= 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            position <= '0;
            line_count <= '0;
            phase <= 2'h0;
            direction_up <= 1'b1;
        end
        else
        begin
            position <= next_position;
            line_count <= next_line_count;
            if (fwd)
                phase <= phase + 2'h1;
            else if (rev)
                phase <= phase - 2'h1;
            if (fwd || rev)
                direction_up <= fwd;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            step <= 1'b0;
            double_change <= 1'b0;
            rate_exceeded <= 1'b0;
            gap <= gap_max;
        end
        else
        begin
            step <= fwd || rev;
            double_change <= both_changed;
            rate_exceeded <= too_fast;
            if (fwd || rev)
                gap <= '0;
            else if (gap != gap_max)
                gap <= gap + 1'b1;
        end
    end

    // assertions and cover points
    property p_fwd_counts;
        @(posedge core_clk) disable iff (rst)
        fwd |=> position == $past(position) + 1;
    endproperty
    a_fwd_counts: assert property (p_fwd_counts)
        else $error("forward step did not increment");

    property p_rev_counts;
        @(posedge core_clk) disable iff (rst)
        rev |=> position == $past(position) - 1;
    endproperty
    a_rev_counts: assert property (p_rev_counts)
        else $error("reverse step did not decrement");

    property p_double_flag;
        @(posedge core_clk) disable iff (rst)
        both_changed |=> double_change && !step && $stable(position);
    endproperty
    a_double_flag: assert property (p_double_flag)
        else $error("double change not flagged or counted");

    property p_step_pulse;
        @(posedge core_clk) disable iff (rst)
        step |-> $past(cur != prev) && $past(primed);
    endproperty
    a_step_pulse: assert property (p_step_pulse)
        else $error("step without input change");

    property p_line_four;
        @(posedge core_clk) disable iff (rst)
        line_up |=> line_count == $past(line_count) + 1 && phase == 2'h0;
    endproperty
    a_line_four: assert property (p_line_four)
        else $error("line count not advanced after four steps");

    property p_rate;
        @(posedge core_clk) disable iff (rst)
        (fwd || rev) ##[1:40] (fwd || rev) |=> rate_exceeded;
    endproperty
    a_rate: assert property (p_rate)
        else $error("closely spaced steps not flagged as too fast");

    property p_dir;
        @(posedge core_clk) disable iff (rst)
        rev |=> !direction_up;
    endproperty
    a_dir: assert property (p_dir)
        else $error("direction not tracked");

    property p_quiet;
        @(posedge core_clk) disable iff (rst)
        !changed |=> $stable(position) && !step;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("count moved without state change");

    property p_line_back;
        @(posedge core_clk) disable iff (rst)
        line_dn |=> line_count == $past(line_count) - 1 && phase == 2'h3;
    endproperty
    a_line_back: assert property (p_line_back)
        else $error("line count not reduced at line boundary");

    property p_line_hold;
        @(posedge core_clk) disable iff (rst)
        fwd && phase != 2'h3 |=> $stable(line_count);
    endproperty
    a_line_hold: assert property (p_line_hold)
        else $error("line count moved inside a line");

    property p_dir_fwd;
        @(posedge core_clk) disable iff (rst)
        fwd |=> direction_up;
    endproperty
    a_dir_fwd: assert property (p_dir_fwd)
        else $error("forward direction not tracked");

    property p_double_hold;
        @(posedge core_clk) disable iff (rst)
        both_changed |=> $stable(line_count) && $stable(direction_up);
    endproperty
    a_double_hold: assert property (p_double_hold)
        else $error("double change moved line count or direction");

    property p_fast_step;
        @(posedge core_clk) disable iff (rst)
        rate_exceeded |-> step && !double_change;
    endproperty
    a_fast_step: assert property (p_fast_step)
        else $error("rate flag without a valid step");

    // a single pin edge reaches the step pulse after sync and decode
    property p_pin_to_step;
        @(posedge core_clk) disable iff (rst)
        ($changed(chan_first) != $changed(chan_second)) |-> ##3 step;
    endproperty
    a_pin_to_step: assert property (p_pin_to_step)
        else $error("single pin change did not give a step");

    c_fwd: cover property (@(posedge core_clk) disable iff (rst) fwd);
    c_rev: cover property (@(posedge core_clk) disable iff (rst) rev);
    c_double: cover property (@(posedge core_clk) disable iff (rst)
        both_changed);
    c_line: cover property (@(posedge core_clk) disable iff (rst) line_up);
    c_fast: cover property (@(posedge core_clk) disable iff (rst) too_fast);
endmodule
`default_nettype wire

// ==== hdl/qdec_pkg.sv ====
package qdec_pkg;
    // maximum count rate of the encoder, kHz
    localparam int count_rate_limit_khz = 60;
    localparam int core_clk_khz = 40000;
    // clock cycles per count at the limit, rounded down
    localparam int count_period_cycles = core_clk_khz / count_rate_limit_khz;
    // states per cycle
    localparam int states_per_cycle = 4;
    localparam int pos_width = 32;
    localparam int gap_width = 16;
    localparam logic [15:0] gap_max = 16'hffff;
    // resolution variants, lines per inch
    localparam int lpi_low = 150;
    localparam int lpi_mid = 300;
    localparam int lpi_high = 360;
endpackage

// ==== hdl/pin_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser, one per bit
module pin_sync #(
    parameter int width = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [width-1:0] pin,
    output logic [width-1:0] sync
);
    logic [width-1:0] meta;

    genvar i;
    generate
        for (i = 0; i < width; i++)
        begin : g_bit
            always_ff @(posedge core_clk)
            begin
                if (rst)
                begin
                    meta[i] <= 1'b0;
                    sync[i] <= 1'b0;
                end
                else
                begin
                    meta[i] <= pin[i];
                    sync[i] <= meta[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ==== sim/encoder_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// encoder pins, one gray state per advance
module encoder_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // motion requests
    input wire logic adv,
    input wire logic fwd,
    input wire logic jump,
    // encoder pins
    output logic chan_first,
    output logic chan_second
);
    logic [1:0] s;
    always_ff @(posedge core_clk)
    begin
        if (rst)
            s <= 2'h0;
        else if (jump)
            s <= s + 2'h2;
        else if (adv)
            s <= fwd ? s + 2'h1 : s - 2'h1;
    end
    // each pin high two states of four, one state apart
    assign chan_first = s[0] ^ s[1];
    assign chan_second = s[1];
endmodule
`default_nettype wire

// ==== sim/quadrature_decoder_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module quadrature_decoder_bench;
    import qdec_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic adv = 1'b0;
    logic fwd = 1'b1;
    logic jump = 1'b0;
    logic a, b, direction_up, step, double_change, rate_exceeded;
    logic [pos_width-1:0] position, line_count;
    int n_fail = 0, check_count = 0, n_step = 0, n_dbl = 0, n_fast = 0;
    always #12.5 core_clk = ~core_clk;
    encoder_model enc_u (.core_clk(core_clk), .rst(rst), .adv(adv),
        .fwd(fwd), .jump(jump), .chan_first(a), .chan_second(b));
    quadrature_decoder dut_u (.core_clk(core_clk), .rst(rst),
        .chan_first(a), .chan_second(b), .position(position),
        .line_count(line_count), .direction_up(direction_up),
        .step(step), .double_change(double_change),
        .rate_exceeded(rate_exceeded));
    always @(posedge core_clk)
    begin
        if (step === 1'b1) n_step++;
        if (double_change === 1'b1) n_dbl++;
        if (rate_exceeded === 1'b1) n_fast++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic move(input logic up, input int n, input int gap);
        for (int i = 0; i < n; i++)
        begin
            @(posedge core_clk);
            fwd <= up;
            adv <= 1'b1;
            @(posedge core_clk);
            adv <= 1'b0;
            repeat (gap) @(posedge core_clk);
        end
    endtask
    task automatic t_reset();
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        repeat (10) @(posedge core_clk);
        check(position, 32'h0);
        check(line_count, 32'h0);
        check(direction_up, 32'h1);
        check(n_step, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_up();
        move(1'b1, 8, 200);
        check(position, 32'h8);
        check(line_count, 32'h2);
        check(direction_up, 32'h1);
        check(n_fast, 32'h0);
        $display("up test done");
    endtask
    task automatic t_down();
        move(1'b0, 12, 200);
        check(position, 32'hfffffffc);
        check(line_count, 32'hffffffff);
        check(direction_up, 32'h0);
        $display("down test done");
    endtask
    task automatic t_fast();
        move(1'b1, 4, 20);
        check(position, 32'h0);
        check(n_fast, 32'h3);
        check(line_count, 32'h0);
        $display("rate test done");
    endtask
    task automatic t_double();
        @(posedge core_clk);
        jump <= 1'b1;
        @(posedge core_clk);
        jump <= 1'b0;
        repeat (10) @(posedge core_clk);
        check(n_dbl, 32'h1);
        check(n_step, 32'h18);
        check(position, 32'h0);
        $display("double change test done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #250000;
        n_fail++;
        conclude();
    end
    initial
    begin
        t_reset();
        t_up();
        t_down();
        t_fast();
        t_double();
        conclude();
    end
endmodule
`default_nettype wire
